// ==== include/cam_trigger_defines.vh ====
// Constants for the exposure-trigger and indicator controller.
// Assumes a 20 MHz system clock and a byte-addressed Avalon-MM slave port.
`ifndef CAM_TRIGGER_DEFINES_VH
`define CAM_TRIGGER_DEFINES_VH

// Clock
`define CLK_MHZ 20

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_EXPOSURE 4'h4
`define REG_READOUT 4'h8
`define REG_STATUS 4'hc

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_COOL_BIT 3
`define CTRL_SYNC_MODE_BIT 4
`define CTRL_RUN_BIT 5
`define CTRL_RESET 6'h00

// Trigger modes
`define MODE_CONTINUAL 3'h0
`define MODE_EDGE_RISE 3'h1
`define MODE_EDGE_FALL 3'h2
`define MODE_LEVEL_HIGH 3'h3
`define MODE_LEVEL_LOW 3'h4
`define MODE_SOFTWARE 3'h5

// Status register: write bit 0 is the software trigger
`define STATUS_SWTRIG_BIT 0

// Timing, microseconds and derived cycle counts
`define TIME_W 24
`define EXPOSURE_DEFAULT_US 1000
`define READOUT_DEFAULT_US 2000
`define EXPOSURE_DEFAULT_CYC (`EXPOSURE_DEFAULT_US * `CLK_MHZ)
`define READOUT_DEFAULT_CYC (`READOUT_DEFAULT_US * `CLK_MHZ)

`endif

// ==== src/pin_sync.v ====
// Two-flop synchronisers for asynchronous pins, one per bit.
// Assumes inputs come from outside the clk domain.
module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins and synchronised copies
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] stage1_r;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      stage1_r <= {WIDTH{1'b0}};
      pinSync <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= pinIn;
      pinSync <= stage1_r;
    end
  end

endmodule

// ==== src/camera_exposure_trigger_control.v ====
// Exposure trigger, sync outputs and indicator lamps of a digital camera.
// Assumes one 20 MHz clock, a synchronous reset and an Avalon-MM master.
// Summary of operation
// - Edge modes start integration on the chosen transition of the trigger input.
// - Edge modes time integration from the exposure register, not the trigger width.
// - Edge modes may expose while the previous frame is still reading out.
// - Level-high mode integrates from a rising trigger edge seen in idle until the trigger level goes low.
// - Level-low mode integrates from a falling trigger edge seen in idle until the trigger level goes high.
// - The exposure lamp is lit while integrating and dark otherwise.
// - The cooling lamp is lit only on cooled variants with cooling enabled.
// - The power lamp is lit whenever the camera is switched on.
// - The trigger pin is active low.
// - The readout sync output is high for the whole of sensor readout.
// - The second sync output shows exposure or trigger mask by configured mode.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`include "cam_trigger_defines.vh"

module camera_exposure_trigger_control (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // External pins
  input wire triggerInN,
  input wire powerSwitch,
  input wire cooledVariant,
  // Sensor and sync outputs
  output wire integrate,
  output wire readoutSync,
  output wire exposure_mask_output,
  // Indicator lamps
  output reg powerLamp,
  output reg exposureLamp,
  output reg coolingLamp
);

  localparam ST_IDLE = 2'd0;
  localparam ST_EXPOSE = 2'd1;
  localparam ST_HOLD = 2'd2;

  wire [2:0] pinSync;
  reg trigLevelPrev_r;
  reg ackR;
  reg [5:0] ctrl_r;
  reg [`TIME_W-1:0] exposureLen_r;
  reg [`TIME_W-1:0] readoutLen_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`TIME_W-1:0] expCnt_r;
  reg [`TIME_W-1:0] rdCnt_r;
  reg [15:0] frameCount_r;
  reg swTrig;
  reg startReq;
  reg stopReq;

  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({cooledVariant, powerSwitch, ~triggerInN}),
    .pinSync(pinSync)
  );

  // Inverted ahead of the flops so their reset value is the idle level; no false edge after reset
  wire trigLevel = pinSync[0];
  // Integer defaults cut to the timer width on purpose
  wire [31:0] exposureDefault = `EXPOSURE_DEFAULT_CYC;
  wire [31:0] readoutDefault = `READOUT_DEFAULT_CYC;
  wire trigRise = trigLevel & ~trigLevelPrev_r;
  wire trigFall = ~trigLevel & trigLevelPrev_r;
  wire [2:0] mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire readoutBusy = (rdCnt_r != {`TIME_W{1'b0}});
  wire busAccess = read | write;
  wire busDone = busAccess & ackR;

  // One wait state on every access; the answer edge is the second one
  assign waitrequest = busAccess & ~ackR;

  always @(posedge clk) begin
    if (rst) begin
      trigLevelPrev_r <= 1'b0;
    end else begin
      trigLevelPrev_r <= trigLevel;
    end
  end

  // Bus slave: registers take writes at the edge where waitrequest is low
  always @(posedge clk) begin
    if (rst) begin
      ackR <= 1'b0;
      ctrl_r <= `CTRL_RESET;
      exposureLen_r <= exposureDefault[`TIME_W-1:0];
      readoutLen_r <= readoutDefault[`TIME_W-1:0];
      readdata <= 32'h0000_0000;
    end else begin
      ackR <= busAccess & ~ackR;
      if (write & ackR) begin
        case (address)
          `REG_CTRL: begin
            ctrl_r <= writedata[5:0];
          end
          `REG_EXPOSURE: begin
            exposureLen_r <= writedata[`TIME_W-1:0];
          end
          `REG_READOUT: begin
            readoutLen_r <= writedata[`TIME_W-1:0];
          end
          default: begin
          end
        endcase
      end
      // Data captured one edge early so it stands at the answer edge
      if (read & ~ackR) begin
        case (address)
          `REG_CTRL: begin
            readdata <= {26'h000_0000, ctrl_r};
          end
          `REG_EXPOSURE: begin
            readdata <= {8'h00, exposureLen_r};
          end
          `REG_READOUT: begin
            readdata <= {8'h00, readoutLen_r};
          end
          `REG_STATUS: begin
            readdata <= {frameCount_r, 12'h000, readoutBusy, state_r, integrate};
          end
          default: begin
            readdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always @* begin
    swTrig = write & ackR & (address == `REG_STATUS) & writedata[`STATUS_SWTRIG_BIT];
  end

  // Start sources per mode; external edges count only in external modes
  always @* begin
    startReq = 1'b0;
    stopReq = 1'b0;
    case (mode)
      `MODE_CONTINUAL: begin
        startReq = ctrl_r[`CTRL_RUN_BIT] & ~readoutBusy;
        stopReq = (expCnt_r >= exposureLen_r);
      end
      `MODE_EDGE_RISE: begin
        startReq = trigRise;
        stopReq = (expCnt_r >= exposureLen_r);
      end
      `MODE_EDGE_FALL: begin
        startReq = trigFall;
        stopReq = (expCnt_r >= exposureLen_r);
      end
      `MODE_LEVEL_HIGH: begin
        startReq = trigRise;
        stopReq = ~trigLevel;
      end
      `MODE_LEVEL_LOW: begin
        startReq = trigFall;
        stopReq = trigLevel;
      end
      `MODE_SOFTWARE: begin
        startReq = swTrig;
        stopReq = (expCnt_r >= exposureLen_r);
      end
      default: begin
        startReq = 1'b0;
        stopReq = 1'b1;
      end
    endcase
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // Idle is reachable while readout runs, so edge triggers overlap it
        if (startReq) begin
          state_nxt = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (stopReq) begin
          state_nxt = readoutBusy ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!readoutBusy) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Exposure timer, readout timer and frame counter
  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      expCnt_r <= {`TIME_W{1'b0}};
      rdCnt_r <= {`TIME_W{1'b0}};
      frameCount_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        expCnt_r <= {{(`TIME_W-1){1'b0}}, 1'b1};
      end else if (state_r == ST_EXPOSE) begin
        expCnt_r <= expCnt_r + {{(`TIME_W-1){1'b0}}, 1'b1};
      end
      // Frame leaves the sensor once exposure is over and readout is free
      if ((state_r == ST_EXPOSE && stopReq && !readoutBusy) || (state_r == ST_HOLD && !readoutBusy)) begin
        rdCnt_r <= (readoutLen_r == {`TIME_W{1'b0}}) ? {{(`TIME_W-1){1'b0}}, 1'b1} : readoutLen_r;
        frameCount_r <= frameCount_r + 16'h0001;
      end else if (readoutBusy) begin
        rdCnt_r <= rdCnt_r - {{(`TIME_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign integrate = (state_r == ST_EXPOSE);
  assign readoutSync = readoutBusy;
  // With the sync mode bit set, mask is high whenever a new trigger would not be taken; otherwise it follows integrate
  assign exposure_mask_output = ctrl_r[`CTRL_SYNC_MODE_BIT] ? (state_r != ST_IDLE) : integrate;

  // Lamps; cooled strap is read only after reset has been released
  always @(posedge clk) begin
    if (rst) begin
      powerLamp <= 1'b0;
      exposureLamp <= 1'b0;
      coolingLamp <= 1'b0;
    end else begin
      powerLamp <= pinSync[1];
      exposureLamp <= integrate;
      coolingLamp <= pinSync[2] & ctrl_r[`CTRL_COOL_BIT];
    end
  end

endmodule

// ==== tb/cam_trigger_properties.sv ====
// Port checker for the trigger controller.
// Assumes writes land at the edge where waitrequest is low.
`include "cam_trigger_defines.vh"
module cam_trigger_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register bus
  input wire write,
  input wire waitrequest,
  input wire [3:0] address,
  input wire [31:0] writedata,
  // Pins
  input wire triggerInN,
  input wire powerSwitch,
  // Outputs watched
  input wire integrate,
  input wire readoutSync,
  input wire exposure_mask_output,
  input wire powerLamp,
  input wire exposureLamp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_r;
  logic cool_r, maskMode_r, run_r;
  logic [23:0] exp_r, ro_r, expCnt_r, roCnt_r;
  wire take = write && !waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk) begin
    expCnt_r <= integrate ? expCnt_r + 24'h1 : 24'h0;
    roCnt_r <= readoutSync ? roCnt_r + 24'h1 : 24'h0;
    if (rst) begin
      {run_r, maskMode_r, cool_r, mode_r} <= 6'h00;
      exp_r <= 24'(`EXPOSURE_DEFAULT_CYC);
      ro_r <= 24'(`READOUT_DEFAULT_CYC);
    end else if (take && address == `REG_CTRL) begin
      {run_r, maskMode_r, cool_r, mode_r} <= writedata[5:0];
    end else if (take && address == `REG_EXPOSURE) begin
      exp_r <= writedata[23:0];
    end else if (take && address == `REG_READOUT) begin
      ro_r <= writedata[23:0];
    end
  end
  // Idle only: checked while neither integrating nor reading out
  AST_EDGE: assert property (!integrate && !readoutSync && (mode_r == `MODE_EDGE_RISE ? $fell(triggerInN) :
    mode_r == `MODE_EDGE_FALL && $rose(triggerInN)) |-> ##[1:5] integrate) else $error("edge start");
  AST_TLEN: assert property (mode_r != `MODE_LEVEL_HIGH && mode_r != `MODE_LEVEL_LOW && $fell(integrate)
    |-> expCnt_r == (exp_r > 24'h1 ? exp_r : 24'h1)) else $error("exposure length");
  AST_HI_END: assert property (mode_r == `MODE_LEVEL_HIGH && $rose(triggerInN) |-> ##[1:4] !integrate)
    else $error("level high end");
  AST_LO_END: assert property (mode_r == `MODE_LEVEL_LOW && $fell(triggerInN) |-> ##[1:4] !integrate)
    else $error("level low end");
  AST_LAMP: assert property (1'b1 |=> exposureLamp == $past(integrate)) else $error("exposure lamp");
  AST_PWR: assert property ($stable(powerSwitch) [*4] |-> powerLamp == powerSwitch) else $error("power lamp");
  AST_RO: assert property ($fell(readoutSync) |-> roCnt_r == (ro_r > 24'h1 ? ro_r : 24'h1))
    else $error("readout length");
  AST_MASK: assert property ((maskMode_r || exposure_mask_output == integrate) && (!integrate || exposure_mask_output))
    else $error("sync output");
endmodule

// ==== tb/trigger_source.sv ====
// Model of the external trigger source on the active-low pin.
// Assumes tasks are called right after a rising clock edge.
module trigger_source (
  input wire logic clk,
  output logic triggerInN
);
  timeunit 1ns;
  timeprecision 1ns;
  initial triggerInN = 1'b1; // Idle inactive
  task automatic drive(input logic v); // Clean logic levels only
    triggerInN <= v;
  endtask
  task automatic pulse(input int n);
    drive(1'b0);
    repeat (n) @(posedge clk);
    drive(1'b1);
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Bench for the trigger controller: bus tasks and trigger scenarios.
// Assumes the trigger source model drives the trigger pin.
`include "cam_trigger_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, powerSwitch = 1'h1, cooledVariant = 1'h1;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, rdata, t0, intTotal = 32'h0;
  wire triggerInN, waitrequest, integrate, readoutSync, exposure_mask_output, powerLamp, exposureLamp, coolingLamp;
  wire [31:0] readdata;
  int errors = 0, n_checks = 0, cyc = 0;
  camera_exposure_trigger_control u_camera_exposure_trigger_control (
    .clk(clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .triggerInN(triggerInN),
    .powerSwitch(powerSwitch),
    .cooledVariant(cooledVariant),
    .integrate(integrate),
    .readoutSync(readoutSync),
    .exposure_mask_output(exposure_mask_output),
    .powerLamp(powerLamp),
    .exposureLamp(exposureLamp),
    .coolingLamp(coolingLamp)
  );
  trigger_source u_trigger_source (.clk(clk), .triggerInN(triggerInN));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    intTotal <= intTotal + {31'h0, integrate === 1'b1};
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held to the edge that samples waitrequest low; one idle cycle between requests
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitFor(input logic v);
    @(posedge clk);
    while (integrate !== v) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1, `REG_EXPOSURE, 0);
    chk(rdata, `EXPOSURE_DEFAULT_CYC);
    bus(0, 4'h1, 32'h5);
    bus(1, 4'h1, 0);
    chk(rdata, 0);
    bus(0, `REG_EXPOSURE, 5);
    bus(0, `REG_READOUT, 30);
    bus(0, `REG_CTRL, 32'hffffffc9);
    bus(1, `REG_CTRL, 0);
    chk(rdata, 32'h9);
    repeat (5) @(posedge clk);
    chk(coolingLamp, 1);
    chk(powerLamp, 1);
    t0 = intTotal;
    u_trigger_source.pulse(2);
    waitFor(1);
    waitFor(0);
    u_trigger_source.pulse(2);
    waitFor(1);
    chk(readoutSync, 1);
    waitFor(0);
    chk(intTotal - t0, 10);
    cooledVariant <= 1'b0;
    repeat (5) @(posedge clk);
    chk(coolingLamp, 0);
    cooledVariant <= 1'b1;
    repeat (40) @(posedge clk);
    bus(0, `REG_CTRL, 32'h12);
    repeat (3) @(posedge clk);
    chk(coolingLamp, 0);
    t0 = intTotal;
    u_trigger_source.pulse(10);
    chk(intTotal - t0, 0);
    waitFor(1);
    waitFor(0);
    chk(intTotal - t0, 5);
    repeat (40) @(posedge clk);
    bus(0, `REG_CTRL, `MODE_LEVEL_HIGH);
    t0 = intTotal;
    u_trigger_source.pulse(20);
    repeat (8) @(posedge clk);
    chk((intTotal - t0) inside {[19:21]}, 1);
    repeat (40) @(posedge clk);
    bus(0, `REG_CTRL, `MODE_LEVEL_LOW);
    u_trigger_source.drive(1'b0);
    repeat (10) @(posedge clk);
    t0 = intTotal;
    u_trigger_source.drive(1'b1);
    repeat (12) @(posedge clk);
    u_trigger_source.drive(1'b0);
    repeat (8) @(posedge clk);
    chk((intTotal - t0) inside {[11:13]}, 1);
    bus(0, `REG_CTRL, `MODE_CONTINUAL);
    t0 = intTotal;
    u_trigger_source.drive(1'b1);
    repeat (10) @(posedge clk);
    chk(intTotal - t0, 0);
    bus(0, `REG_CTRL, 32'h20);
    waitFor(1);
    waitFor(0);
    chk(intTotal - t0, 5);
    bus(0, `REG_CTRL, `MODE_SOFTWARE);
    u_trigger_source.pulse(4);
    repeat (8) @(posedge clk);
    bus(0, `REG_STATUS, 1);
    waitFor(0);
    chk(intTotal - t0, 10);
    powerSwitch <= 1'b0;
    repeat (5) @(posedge clk);
    chk(powerLamp, 0);
    repeat (60) @(posedge clk);
    bus(1, `REG_STATUS, 0);
    chk(rdata, 32'h0007_0000);
    end_of_test;
  end
endmodule
bind camera_exposure_trigger_control cam_trigger_properties u_cam_trigger_properties (
  .clk(clk),
  .rst(rst),
  .write(write),
  .waitrequest(waitrequest),
  .address(address),
  .writedata(writedata),
  .triggerInN(triggerInN),
  .powerSwitch(powerSwitch),
  .integrate(integrate),
  .readoutSync(readoutSync),
  .exposure_mask_output(exposure_mask_output),
  .powerLamp(powerLamp),
  .exposureLamp(exposureLamp)
);
